// ==== design/ccs_clock_config_select.sv ====
/*
 * ccs_clock_config_select: power-up strap latch, configuration selection,
 * run-time select switching, reference source choice and spread control.
 * Assumes i_rst is the power-on reset and pins are synchronous inputs.
 */
`timescale 1ns/1ps
module ccs_clock_config_select
	import ccs_pkg::*;
(
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	// strap / reference output pin
	input  wire logic         i_strap_select_pin,
	output logic              o_strap_select_pin,
	output logic              o_strap_select_oe,
	input  wire logic         i_ref_clk,
	// shared pins
	input  wire logic         i_config_select_hi,
	input  wire logic         i_config_select_lo,
	output logic              o_i2c_enable,
	// stored flag from nonvolatile bank 0
	input  wire logic         i_stored_default_flag,
	// register port from i2c engine
	input  wire ccs_reg_req_t i_reg_req,
	output logic [7:0]        o_reg_rdata,
	output logic              o_reg_ready,
	// configuration loader
	output ccs_load_t         o_load,
	input  wire logic         i_load_done,
	// reference source
	input  wire logic         i_input_clock_select_pin,
	output logic              o_sel_diff_clock_input,
	output logic              o_switch_pending,
	// spread to output divider
	output logic [7:0]        o_spread_cfg
);
	// =====================================================================
	// state
	typedef enum logic [2:0] {
		CCS_ST_SAMPLE, CCS_ST_LOAD, CCS_ST_RUN_HOLD, CCS_ST_RUN
	} ccs_state_t;

	ccs_state_t  state_r, state_nxt;
	logic        strap_r, strap_nxt;
	logic        flag_r, flag_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	ccs_cfg_t    cfg_r, cfg_nxt;
	logic        load_r, load_nxt;
	logic [7:0]  src_r, src_nxt;
	logic [7:0]  spr_r, spr_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic        sel_r, sel_nxt;
	logic        hi_lvl, hi_chg, lo_lvl, lo_chg;

	function automatic ccs_cfg_t cfg_of(input logic hi, input logic lo);
		cfg_of = ccs_cfg_t'({1'b0, hi, lo});
	endfunction : cfg_of

	function automatic logic spread_ok(input logic [7:0] v);
		if (!v[7])
			spread_ok = 1'b1;
		else if (v[6])
			spread_ok = (v[5:0] >= CCS_SPREAD_DN_MIN) &&
				(v[5:0] <= CCS_SPREAD_DN_MAX);
		else
			spread_ok = (v[5:0] != 6'h00) &&
				(v[5:0] <= CCS_SPREAD_CTR_MAX);
	endfunction : spread_ok

	// floating pins arrive low, so a plain sync is enough
	ccs_sel_filter u_hi (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_config_select_hi),
		.o_level    (hi_lvl),
		.o_change   (hi_chg)
	);
	ccs_sel_filter u_lo (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_config_select_lo),
		.o_level    (lo_lvl),
		.o_change   (lo_chg)
	);

	wire reg_ok   = (state_r == CCS_ST_RUN) || (state_r == CCS_ST_RUN_HOLD);
	wire i2c_on   = reg_ok && !strap_r;
	wire manual   = !src_r[CCS_SM_LSB + 1];
	wire sel_chg  = hi_chg || lo_chg;

	// =====================================================================
	// next state
	always_comb begin
		state_nxt = state_r;
		strap_nxt = strap_r;
		flag_nxt  = flag_r;
		cnt_nxt   = cnt_r;
		cfg_nxt   = cfg_r;
		load_nxt  = 1'b0;
		src_nxt   = src_r;
		spr_nxt   = spr_r;
		rdata_nxt = rdata_r;
		sel_nxt   = sel_r;
		case (state_r)
			CCS_ST_SAMPLE: begin
				// wait for select sync to settle before trusting levels
				if (cnt_r >= CCS_SYNC_CYC) begin
					strap_nxt = i_strap_select_pin;
					flag_nxt  = i_stored_default_flag;
					if (i_strap_select_pin)
						cfg_nxt = cfg_of(hi_lvl, lo_lvl);
					else if (i_stored_default_flag)
						cfg_nxt = CCS_CFG_DEFAULTS;
					else
						cfg_nxt = CCS_CFG_0;
					load_nxt  = 1'b1;
					cnt_nxt   = '0;
					state_nxt = CCS_ST_LOAD;
				end else begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			CCS_ST_LOAD: begin
				// minimum 1 ms apply window, longer if loader is slow
				if (cnt_r < CCS_LOAD_CYC)
					cnt_nxt = cnt_r + 32'h1;
				if (i_load_done && cnt_r >= CCS_LOAD_CYC - 1) begin
					cnt_nxt   = '0;
					state_nxt = CCS_ST_RUN_HOLD;
				end
			end
			CCS_ST_RUN_HOLD: begin
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r >= CCS_RUN_HOLD_CYC - 1)
					state_nxt = CCS_ST_RUN;
			end
			CCS_ST_RUN: begin
				// select changes reload only in pin mode, flag 0
				if (strap_r && !flag_r && sel_chg) begin
					cfg_nxt   = cfg_of(hi_lvl, lo_lvl);
					load_nxt  = 1'b1;
					cnt_nxt   = '0;
					state_nxt = CCS_ST_LOAD;
				end
			end
			default: state_nxt = CCS_ST_SAMPLE;
		endcase
		// register port
		if (i2c_on && i_reg_req.wr) begin
			if (i_reg_req.addr == CCS_ADDR_INPUT_SRC)
				src_nxt = i_reg_req.wdata;
			if (i_reg_req.addr == CCS_ADDR_SPREAD &&
				spread_ok(i_reg_req.wdata))
				spr_nxt = i_reg_req.wdata;
		end
		if (i2c_on && i_reg_req.rd) begin
			case (i_reg_req.addr)
				CCS_ADDR_FLAGS:     rdata_nxt = {flag_r, 7'h00};
				CCS_ADDR_INPUT_SRC: rdata_nxt = src_r;
				CCS_ADDR_SPREAD:    rdata_nxt = spr_r;
				CCS_ADDR_STATUS:
					rdata_nxt = {3'h0, strap_r, sel_r, cfg_r};
				default:            rdata_nxt = 8'h00;
			endcase
		end
		// select pin only steers in manual mode; retimed to one edge
		if (manual)
			sel_nxt = i_input_clock_select_pin ^
				src_r[CCS_POL_BIT];
	end

	// =====================================================================
	// registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= CCS_ST_SAMPLE;
			strap_r <= 1'b0;
			flag_r  <= 1'b0;
			cnt_r   <= '0;
			cfg_r   <= CCS_CFG_0;
			load_r  <= 1'b0;
			src_r   <= CCS_INPUT_SRC_RST;
			spr_r   <= CCS_SPREAD_RST;
			rdata_r <= 8'h00;
			sel_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			strap_r <= strap_nxt;
			flag_r  <= flag_nxt;
			cnt_r   <= cnt_nxt;
			cfg_r   <= cfg_nxt;
			load_r  <= load_nxt;
			src_r   <= src_nxt;
			spr_r   <= spr_nxt;
			rdata_r <= rdata_nxt;
			sel_r   <= sel_nxt;
		end
	end

	// =====================================================================
	// outputs
	assign o_strap_select_oe      = (state_r != CCS_ST_SAMPLE);
	assign o_strap_select_pin     = o_strap_select_oe & i_ref_clk;
	assign o_i2c_enable           = i2c_on;
	assign o_reg_ready            = i2c_on;
	assign o_reg_rdata            = rdata_r;
	assign o_load                 = '{load_req: load_r, cfg: cfg_r};
	assign o_sel_diff_clock_input = sel_r;
	assign o_switch_pending       = (state_r == CCS_ST_LOAD);
	assign o_spread_cfg           = spr_r;

	// =====================================================================
	// checks
	AST_STRAP_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_r != CCS_ST_SAMPLE |=> $stable(strap_r))
		else $error("strap latch changed after sampling");
	AST_PIN_DRIVE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_r == CCS_ST_LOAD |-> o_strap_select_oe)
		else $error("strap pin not driven after sampling");
	AST_NO_I2C_STRAP_HI: assert property (@(posedge i_core_clk)
		disable iff (i_rst) strap_r |-> !o_i2c_enable)
		else $error("i2c open with strap high");
	AST_NO_I2C_BEFORE_LOAD: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		state_r inside {CCS_ST_SAMPLE, CCS_ST_LOAD} |-> !o_i2c_enable)
		else $error("i2c open before restore");
	AST_CFG_SEL: assert property (@(posedge i_core_clk) disable iff (i_rst)
		load_r && strap_r |->
		cfg_r == cfg_of($past(hi_lvl), $past(lo_lvl)))
		else $error("wrong pin configuration loaded");
	AST_CFG_I2C: assert property (@(posedge i_core_clk) disable iff (i_rst)
		load_r && !strap_r |-> cfg_r ==
		(flag_r ? CCS_CFG_DEFAULTS : CCS_CFG_0))
		else $error("wrong i2c-mode configuration");
	AST_SRC_MAP: assert property (@(posedge i_core_clk) disable iff (i_rst)
		manual |=> o_sel_diff_clock_input ==
		($past(i_input_clock_select_pin) ^ $past(src_r[CCS_POL_BIT])))
		else $error("source choice wrong");
	AST_AUTO_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!$past(manual) |-> $stable(o_sel_diff_clock_input))
		else $error("select pin acted outside manual mode");
	AST_HOLD_10MS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_r == CCS_ST_RUN_HOLD && sel_chg |=> !load_r)
		else $error("reload inside 10 ms window");
	AST_SPREAD_LIMIT: assert property (@(posedge i_core_clk)
		disable iff (i_rst) spread_ok(spr_r))
		else $error("spread setting out of range");
endmodule : ccs_clock_config_select

// ==== design/ccs_pkg.sv ====
/*
 * ccs_pkg: constants and carrier types for the clock configuration select
 * block. Assumes a 50 MHz core clock and a byte-wide register port.
 */
package ccs_pkg;
	// =====================================================================
	// clock and timing
	localparam int unsigned CCS_CLK_HZ       = 50000000;
	localparam int unsigned CCS_RUN_HOLD_MS  = 10;
	localparam int unsigned CCS_LOAD_HOLD_MS = 1;
	localparam int unsigned CCS_RUN_HOLD_CYC =
		CCS_CLK_HZ / 1000 * CCS_RUN_HOLD_MS;
	localparam int unsigned CCS_LOAD_CYC     =
		CCS_CLK_HZ / 1000 * CCS_LOAD_HOLD_MS;
	localparam int unsigned CCS_SYNC_CYC     = 2;
	// =====================================================================
	// register map
	localparam logic [7:0] CCS_ADDR_FLAGS     = 8'h00;
	localparam logic [7:0] CCS_ADDR_INPUT_SRC = 8'h13;
	localparam logic [7:0] CCS_ADDR_SPREAD    = 8'h20;
	localparam logic [7:0] CCS_ADDR_STATUS    = 8'h21;
	localparam int unsigned CCS_FLAG_BIT      = 7;
	localparam int unsigned CCS_POL_BIT       = 1;
	localparam int unsigned CCS_SM_LSB        = 6;
	localparam logic [7:0] CCS_INPUT_SRC_RST  = 8'h00;
	localparam logic [7:0] CCS_SPREAD_RST     = 8'h00;
	// spread: bit7 enable, bit6 down(1)/center(0), bits5:0 amount, 0.1 %
	localparam logic [5:0] CCS_SPREAD_CTR_MAX = 6'h19;
	localparam logic [5:0] CCS_SPREAD_DN_MIN  = 6'h05;
	localparam logic [5:0] CCS_SPREAD_DN_MAX  = 6'h32;
	// =====================================================================
	// types
	typedef enum logic [2:0] {
		CCS_CFG_0, CCS_CFG_1, CCS_CFG_2, CCS_CFG_3, CCS_CFG_DEFAULTS
	} ccs_cfg_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccs_reg_req_t;

	typedef struct packed {
		logic       load_req;
		ccs_cfg_t   cfg;
	} ccs_load_t;
endpackage : ccs_pkg

// ==== design/ccs_sel_filter.sv ====
/*
 * ccs_sel_filter: two-stage synchroniser with change pulse for one select
 * pin. Assumes the pin is a clean level; a floating pin arrives as low.
 */
`timescale 1ns/1ps
module ccs_sel_filter
	import ccs_pkg::*;
(
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	// pin
	input  wire logic i_pin,
	// result
	output logic      o_level,
	output logic      o_change
);
	logic meta_r, meta_nxt, lvl_r, lvl_nxt, prev_r, prev_nxt;

	always_comb begin
		meta_nxt = i_pin;
		lvl_nxt  = meta_r;
		prev_nxt = lvl_r;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_r <= 1'b0;
			lvl_r  <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			lvl_r  <= lvl_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign o_level  = lvl_r;
	assign o_change = lvl_r ^ prev_r;
endmodule : ccs_sel_filter

// ==== verif/ccs_board_model.sv ====
/*
 * ccs_board_model: strap resistor and configuration loader stand-in.
 * Assumes the bench picks the strap level before each power-on reset.
 */
`timescale 1ns/1ps
module ccs_board_model
	import ccs_pkg::*;
(
	// clock
	input  wire logic      i_core_clk,
	// board setting
	input  wire logic      i_strap_high,
	// device side
	input  wire ccs_load_t i_load,
	input  wire logic      i_pin_oe,
	input  wire logic      i_pin_drive,
	output logic           o_pin,
	output logic           o_load_done
);
	logic [7:0] wait_r;
	// =====================================================================
	// strap resistor only wins while the device leaves the pin undriven
	assign o_pin = i_pin_oe ? i_pin_drive : i_strap_high;
	initial wait_r = 8'h00;
	always @(posedge i_core_clk) begin
		if (i_load.load_req)
			wait_r <= 8'h64;
		else if (wait_r != 8'h00)
			wait_r <= wait_r - 8'h01;
	end
	// done falls with each request, so a stale done never ends a load
	assign o_load_done = (wait_r == 8'h00) && !i_load.load_req;
endmodule : ccs_board_model

// ==== verif/ccs_clock_config_select_bench.sv ====
/*
 * ccs_clock_config_select_bench: self-checking bench for the block.
 * Assumes the board model stands for the strap resistor and the loader.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module ccs_clock_config_select_bench;
	import ccs_pkg::*;
	logic         i_core_clk, i_rst, strap, pin, ref_clk, sel_hi, sel_lo;
	logic         flag, done, clk_sel, oe, pin_out, i2c, ready, diff, pend;
	logic         rd_q, pol;
	logic [7:0]   rdata, spread, exp_v;
	logic [31:0]  lf;
	ccs_reg_req_t req;
	ccs_load_t    load;
	logic [7:0]   exp_q[$];
	int           n_errors, check_count, cyc;
	ccs_clock_config_select DUT (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_strap_select_pin(pin), .o_strap_select_pin(pin_out),
		.o_strap_select_oe(oe), .i_ref_clk(ref_clk),
		.i_config_select_hi(sel_hi), .i_config_select_lo(sel_lo),
		.o_i2c_enable(i2c), .i_stored_default_flag(flag),
		.i_reg_req(req), .o_reg_rdata(rdata), .o_reg_ready(ready),
		.o_load(load), .i_load_done(done),
		.i_input_clock_select_pin(clk_sel), .o_sel_diff_clock_input(diff),
		.o_switch_pending(pend), .o_spread_cfg(spread));
	ccs_board_model board (.i_core_clk(i_core_clk), .i_strap_high(strap),
		.i_load(load), .i_pin_oe(oe), .i_pin_drive(pin_out), .o_pin(pin),
		.o_load_done(done));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// =====================================================================
	// monitor: oldest note is compared when a result shows
	always @(posedge i_core_clk) begin
		rd_q <= req.rd && ready;
		lf <= lfsr(lf);
		ref_clk <= lf[0];
		cyc++;
		if (cyc == 70000) begin
			n_errors++;
			complete_run();
		end
	end
	always @(negedge i_core_clk) begin
		if (load.load_req || rd_q) begin
			// pop once: the macro names its arguments twice
			exp_v = exp_q.pop_front();
			`CHK(load.load_req ? {5'h00, load.cfg} : rdata, exp_v)
		end
	end
	task automatic complete_run();
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic acc(input logic w, input logic [7:0] a, d);
		if (!w)
			exp_q.push_back(d);
		@(posedge i_core_clk) req <= '{w, !w, a, w ? d : 8'h00};
		@(posedge i_core_clk) req <= '0;
	endtask : acc
	// selects held still through power-up, as the board must
	task automatic boot(input logic s, h, l, f, input logic [7:0] e);
		@(posedge i_core_clk) begin
			i_rst <= 1'b1;
			strap <= s;
			sel_hi <= h;
			sel_lo <= l;
			flag <= f;
		end
		repeat (3) @(posedge i_core_clk);
		#1 `CHK(oe, 1'b0)
		exp_q.push_back(e);
		@(posedge i_core_clk) i_rst <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		#1 `CHK({oe, pin_out, i2c}, {1'b1, ref_clk, 1'b0})
	endtask : boot
	initial begin
		forever #10 i_core_clk = ~i_core_clk;
	end
	initial begin
		{i_core_clk, strap, sel_hi, sel_lo, flag, clk_sel} = '0;
		// reset from time zero so no edge sees unset state
		i_rst = 1'b1;
		{ref_clk, rd_q, req, cyc, n_errors, check_count} = '0;
		lf = 32'h9a95489f;
		for (int k = 0; k < 4; k++)
			boot(1'b1, k[1], k[0], 1'b0, 8'(k));
		boot(1'b0, 1'b1, 1'b1, 1'b1, 8'h04);
		boot(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		// write during restore must be refused; read below expects reset
		acc(1'b1, CCS_ADDR_INPUT_SRC, 8'h02);
		for (int n = 0; n < 60000 && i2c !== 1'b1; n++) begin
			@(posedge i_core_clk);
			#1;
		end
		`CHK(i2c, 1'b1)
		strap <= 1'b1;
		acc(1'b0, CCS_ADDR_INPUT_SRC, 8'h00);
		for (int k = 0; k < 8; k++) begin
			// lfsr moves every cycle, so hold the chosen polarity
			pol = lf[3];
			acc(1'b1, CCS_ADDR_INPUT_SRC, {6'h00, pol, 1'b0});
			acc(1'b0, CCS_ADDR_INPUT_SRC, {6'h00, pol, 1'b0});
			@(posedge i_core_clk) clk_sel <= lf[5];
			repeat (5) @(posedge i_core_clk);
			#1 `CHK(diff, clk_sel ^ pol)
		end
		// same polarity kept so a missing freeze shows a different value
		acc(1'b1, CCS_ADDR_INPUT_SRC, {6'h20, pol, 1'b0});
		@(posedge i_core_clk) clk_sel <= ~clk_sel;
		repeat (5) @(posedge i_core_clk);
		#1 `CHK(diff, ~clk_sel ^ pol)
		acc(1'b0, CCS_ADDR_STATUS, {4'h0, ~clk_sel ^ pol, 3'h0});
		acc(1'b1, CCS_ADDR_SPREAD, 8'hc5);
		acc(1'b1, CCS_ADDR_SPREAD, 8'h9a);
		acc(1'b0, CCS_ADDR_SPREAD, 8'hc5);
		acc(1'b1, CCS_ADDR_SPREAD, 8'h99);
		#1 `CHK(spread, 8'h99)
		`CHK({i2c, oe}, 2'b11)
		`CHK(exp_q.size(), 0)
		complete_run();
	end
endmodule : ccs_clock_config_select_bench
